// File: src/can_rx_irq_pkg.sv
// Constants, field layout and encodings of the receive interrupt enables
package can_rx_irq_pkg;

  localparam int         ADDR_W         = 12;
  localparam int         CNT_W          = 9;

  // Register byte offsets
  localparam logic [11:0] ENABLE_OFFSET = 12'h000;
  localparam logic [11:0] FLAG_OFFSET   = 12'h004;

  // Field positions, shared by enables and flags
  localparam int         WAKE_BIT       = 7;
  localparam int         CSC_BIT        = 6;
  localparam int         RX_SENS_LSB    = 4;
  localparam int         TX_SENS_LSB    = 2;
  localparam int         OVR_BIT        = 1;
  localparam int         RXF_BIT        = 0;

  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  // Enable bits that initialization mode holds at reset value
  localparam logic [7:0] INIT_HOLD_MASK = 8'hC3;

  // Error counter thresholds
  localparam logic [8:0] WARN_LIMIT     = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT  = 9'h080;
  localparam logic [8:0] BUS_OFF_LIMIT  = 9'h100;

  typedef enum logic [1:0] {
    ERR_OK      = 2'b00,
    ERR_WARN    = 2'b01,
    ERR_PASSIVE = 2'b10,
    ERR_BUS_OFF = 2'b11
  } err_state_t;

  typedef enum logic [1:0] {
    SENS_NONE    = 2'b00,
    SENS_BUS_OFF = 2'b01,
    SENS_PASSIVE = 2'b10,
    SENS_ALL     = 2'b11
  } sens_t;

endpackage

// File: src/can_rx_irq_enable.sv
// Receive interrupt enables, state-change flag logic and APB slave
//
// Contract
// [RULE1] Enable writes only outside initialization mode
// [RULE2] Initialization mode holds enables at reset
// [RULE3] Sensitivity fields untouched by initialization mode
// [RULE4] Bit 7 gates wake-up request
// [RULE5] Bit 6 gates state-change error request
// [RULE6] Bits 5-4 select receiver change sensitivity
// [RULE7] Bits 3-2 select transmitter change sensitivity
// [RULE8] Reported states track, frozen while flag pending
// [RULE9] Bit 1 gates overrun error request
// [RULE10] Bit 0 gates receive-full request
// [RULE11] Software reads receive buffer only when full
// [RULE12] Wake needs wake enable and wake function; here the wake request is gated by enable bit 7 alone
// [RULE13] Transmitter state encoded from error counter
// [RULE14] Receiver follows transmitter bus-off and recovery
// [RULE15] Interrupt is OR of flag-and-enable requests
// [RULE16] Flag set only by matching transitions
module can_rx_irq_enable
  import can_rx_irq_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              init_request_i,
  input  wire logic              init_acknowledge_i,
  input  wire logic              wake_event_i,
  input  wire logic              overrun_event_i,
  input  wire logic              rx_msg_event_i,
  input  wire logic [CNT_W-1:0]  rx_err_count_i,
  input  wire logic [CNT_W-1:0]  tx_err_count_i,
  output logic                   wake_irq_o,
  output logic                   error_irq_o,
  output logic                   rx_irq_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic [7:0]  enables;
    logic        wake_flag;
    logic        state_change_flag;
    logic        ovr_flag;
    logic        rx_buffer_full_flag;
    err_state_t  rx_error_state;
    err_state_t  tx_error_state;
    logic [31:0] rdata;
    logic        slverr;
    logic        rd_ok;
    logic        wake_irq;
    logic        error_irq;
    logic        rx_irq;
    logic        irq;
  } state_t;

  localparam state_t ST_RESET = '{
    enables:        ENABLE_RESET,
    rx_error_state: ERR_OK,
    tx_error_state: ERR_OK,
    default:        '0
  };

  state_t      st;
  state_t      next_st;
  logic        in_init;
  logic        access_done;
  logic        wr_enable_reg;
  logic        wr_flag_reg;
  logic [7:0]  clr;
  err_state_t  tx_actual;
  err_state_t  rx_actual;
  logic        rx_hit;
  logic        tx_hit;
  logic [7:0]  flag_view;

  // Counter to error state; the receiver never reports bus-off itself
  function automatic err_state_t encode(input logic [CNT_W-1:0] cnt,
                                        input logic allow_bus_off);
    if (cnt < WARN_LIMIT) begin
      encode = ERR_OK;
    end else if (cnt < PASSIVE_LIMIT) begin
      encode = ERR_WARN;
    end else if (cnt < BUS_OFF_LIMIT || !allow_bus_off) begin
      encode = ERR_PASSIVE;
    end else begin
      encode = ERR_BUS_OFF;
    end
  endfunction

  // Does a transition old -> new count under the given sensitivity
  function automatic logic sens_hit(input logic [1:0] sens,
                                    input err_state_t old_s,
                                    input err_state_t new_s);
    unique case (sens)
      SENS_NONE:    sens_hit = 1'b0;
      SENS_BUS_OFF: sens_hit = (old_s == ERR_BUS_OFF) !=
                               (new_s == ERR_BUS_OFF);
      SENS_PASSIVE: sens_hit = (old_s[1] != new_s[1]) ||
                               ((old_s == ERR_BUS_OFF) !=
                                (new_s == ERR_BUS_OFF));
      SENS_ALL:     sens_hit = old_s != new_s;
    endcase
  endfunction

  assign in_init       = init_request_i & init_acknowledge_i;
  assign pready_o      = penable_i & st.rd_ok & ce_i;
  assign access_done   = psel_i & penable_i & pready_o;
  assign wr_enable_reg = access_done & pwrite_i &
                         (paddr_i == ENABLE_OFFSET);
  assign wr_flag_reg   = access_done & pwrite_i &
                         (paddr_i == FLAG_OFFSET);
  assign clr           = wr_flag_reg ? pwdata_i[7:0] : 8'h00;

  assign tx_actual = encode(tx_err_count_i, 1'b1); // RULE13
  // Bus-off on the transmitter overrides; on recovery each follows its own counter
  assign rx_actual = (tx_actual == ERR_BUS_OFF) ? ERR_BUS_OFF // RULE14
                   : encode(rx_err_count_i, 1'b0);

  assign rx_hit = sens_hit(st.enables[RX_SENS_LSB +: 2], // RULE6
                           st.rx_error_state, rx_actual);
  assign tx_hit = sens_hit(st.enables[TX_SENS_LSB +: 2], // RULE7
                           st.tx_error_state, tx_actual);

  assign flag_view = {st.wake_flag, st.state_change_flag,
                      st.rx_error_state, st.tx_error_state,
                      st.ovr_flag, st.rx_buffer_full_flag};

  always_comb begin
    next_st = st;
    if (ce_i) begin
      // Set wins over a simultaneous write-one clear
      next_st.wake_flag = wake_event_i |
                          (st.wake_flag & ~clr[WAKE_BIT]);
      next_st.ovr_flag = overrun_event_i |
                         (st.ovr_flag & ~clr[OVR_BIT]);
      next_st.rx_buffer_full_flag = rx_msg_event_i |
        (st.rx_buffer_full_flag & ~clr[RXF_BIT]);

      // Blocking flag: reported states freeze until it is cleared
      if (!st.state_change_flag) begin
        next_st.rx_error_state = rx_actual; // RULE8
        next_st.tx_error_state = tx_actual; // RULE8
      end
      next_st.state_change_flag =
        (!st.state_change_flag & (rx_hit | tx_hit)) | // RULE16
        (st.state_change_flag & ~clr[CSC_BIT]);

      if (in_init) begin
        // Sensitivity bits survive; only the enable bits are held
        next_st.enables = (st.enables & ~INIT_HOLD_MASK) | // RULE2 RULE3
                          (ENABLE_RESET & INIT_HOLD_MASK);
      end else if (wr_enable_reg) begin
        next_st.enables = pwdata_i[7:0]; // RULE1
      end

      next_st.wake_irq  = st.wake_flag & st.enables[WAKE_BIT]; // RULE4
      next_st.error_irq =
        (st.state_change_flag & st.enables[CSC_BIT]) | // RULE5 RULE15
        (st.ovr_flag & st.enables[OVR_BIT]); // RULE9
      next_st.rx_irq    = st.rx_buffer_full_flag & // RULE10
                          st.enables[RXF_BIT];
      next_st.irq       = next_st.wake_irq | next_st.error_irq |
                          next_st.rx_irq; // RULE15

      // Read data is captured in the setup cycle, so it is a flop
      if (psel_i && !penable_i) begin
        next_st.rd_ok  = 1'b1;
        next_st.slverr = 1'b0;
        if (paddr_i == ENABLE_OFFSET) begin
          next_st.rdata = {24'h000000, st.enables};
        end else if (paddr_i == FLAG_OFFSET) begin
          next_st.rdata = {24'h000000, flag_view};
        end else begin
          next_st.rdata  = 32'h00000000;
          next_st.slverr = 1'b1;
        end
      end else if (access_done) begin
        next_st.rd_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o    = st.rdata;
  assign pslverr_o   = st.slverr;
  assign wake_irq_o  = st.wake_irq;
  assign error_irq_o = st.error_irq;
  assign rx_irq_o    = st.rx_irq;
  assign irq_o       = st.irq;

  a_init_holds_en: assert property ( // RULE2
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && in_init |=> (st.enables & INIT_HOLD_MASK) == 8'h00)
    else $error("enables not held during init mode");

  a_init_keeps_sens: assert property ( // RULE3
    @(posedge clk_i) disable iff (!rst_b_i)
    in_init |=> $stable(st.enables[5:2]))
    else $error("sensitivity altered in init mode");

  a_write_taken: assert property ( // RULE1
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_enable_reg && !in_init
    |=> st.enables == $past(pwdata_i[7:0]))
    else $error("enable write lost outside init mode");

  a_wake_request: assert property ( // RULE4
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> wake_irq_o ==
      $past(st.wake_flag && st.enables[WAKE_BIT]) ##1 1'b1)
    else $error("wake request does not follow flag and enable");

  a_error_request: assert property ( // RULE9
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && st.ovr_flag && st.enables[OVR_BIT] |=> error_irq_o && irq_o)
    else $error("overrun did not raise error request"); // RULE9

  a_csc_request: assert property ( // RULE15
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !(st.state_change_flag && st.enables[CSC_BIT]) &&
      !(st.ovr_flag && st.enables[OVR_BIT]) |=> !error_irq_o)
    else $error("error request without enabled source");

  a_rx_request: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && st.rx_buffer_full_flag && st.enables[RXF_BIT]
    |=> rx_irq_o ##0 irq_o)
    else $error("receive-full did not raise receive request");

  a_state_frozen: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rst_b_i)
    st.state_change_flag |=> $stable(st.rx_error_state) &&
                             $stable(st.tx_error_state))
    else $error("reported state moved while flag pending");

  a_state_tracks: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !st.state_change_flag
    |=> st.rx_error_state == $past(rx_actual) &&
        st.tx_error_state == $past(tx_actual))
    else $error("reported state does not track actual state");

  a_flag_on_hit: assert property ( // RULE16
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !st.state_change_flag |=>
      st.state_change_flag == $past(rx_hit || tx_hit))
    else $error("state-change flag disagrees with sensitivity");

  a_tx_encoding: assert property ( // RULE13
    @(posedge clk_i) disable iff (!rst_b_i)
    (tx_err_count_i >= BUS_OFF_LIMIT) == (tx_actual == ERR_BUS_OFF) &&
    (tx_err_count_i < WARN_LIMIT) == (tx_actual == ERR_OK))
    else $error("transmitter state encoding wrong");

  a_rx_bus_off: assert property ( // RULE14
    @(posedge clk_i) disable iff (!rst_b_i)
    (tx_actual == ERR_BUS_OFF) == (rx_actual == ERR_BUS_OFF))
    else $error("receiver bus-off not tied to transmitter");

  a_csc_raises: assert property ( // RULE5
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && st.state_change_flag && st.enables[CSC_BIT]
    |=> error_irq_o && irq_o)
    else $error("state change did not raise error request");

  a_wake_masked: assert property ( // RULE4
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !st.enables[WAKE_BIT] |=> !wake_irq_o)
    else $error("masked wake flag raised a request");

  a_rx_masked: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !st.enables[RXF_BIT] |=> !rx_irq_o)
    else $error("masked receive-full raised a request");

  a_irq_is_or: assert property ( // RULE15
    @(posedge clk_i) disable iff (!rst_b_i)
    irq_o == (wake_irq_o || error_irq_o || rx_irq_o))
    else $error("interrupt output is not the OR of requests");

  a_set_wins: assert property ( // RULE9
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && overrun_event_i |=> st.ovr_flag)
    else $error("overrun event did not set its flag");

  a_passive_to_off: assert property ( // RULE6
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !st.state_change_flag && st.enables[RX_SENS_LSB +: 2] ==
      SENS_PASSIVE && st.rx_error_state == ERR_PASSIVE &&
      rx_actual == ERR_BUS_OFF |=> st.state_change_flag)
    else $error("entry into bus-off missed at passive sensitivity");

endmodule

// File: tb/cpu_irq_model.sv
// Interrupt controller model that counts rising interrupt requests
module cpu_irq_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       irq_i,
  output logic      [7:0] irq_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // Level request: only a new rise counts as a fresh interrupt
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      last <= 1'b0;
      irq_seen_o <= 8'h00;
    end else begin
      last <= irq_i;
      if (irq_i && !last) irq_seen_o <= irq_seen_o + 8'h01;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the receive interrupt enable block
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import can_rx_irq_pkg::*;
  logic clk_i, rst_b_i, psel, pen, pwr, init_rq, init_ak;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_o, rd;
  logic [2:0] ev;
  logic [8:0] rxc, txc;
  logic pready_o, pslverr_o, er, wake_irq_o, error_irq_o, rx_irq_o, irq_o;
  logic [7:0] seen;
  int mismatches, n_checks;
  can_rx_irq_enable u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .init_request_i(init_rq),
    .init_acknowledge_i(init_ak), .wake_event_i(ev[2]),
    .overrun_event_i(ev[1]), .rx_msg_event_i(ev[0]),
    .rx_err_count_i(rxc), .tx_err_count_i(txc), .wake_irq_o(wake_irq_o),
    .error_irq_o(error_irq_o), .rx_irq_o(rx_irq_o), .irq_o(irq_o));
  cpu_irq_model u_cpu (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_i(irq_o),
    .irq_seen_o(seen));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic w3;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // Event high for one edge; request shows two edges later
  task automatic pulse(input logic [2:0] v);
    @(posedge clk_i); ev <= v;
    @(posedge clk_i); ev <= 3'h0;
    @(posedge clk_i); #1;
  endtask
  task automatic t_reset;
    chk_reg(ENABLE_OFFSET, 32'h0);
    chk_reg(FLAG_OFFSET, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(er, 1'b1)
  endtask
  task automatic t_init;
    apb(1'b1, ENABLE_OFFSET, 32'hFF);
    chk_reg(ENABLE_OFFSET, 32'hFF);
    init_rq <= 1'b1; init_ak <= 1'b1;
    chk_reg(ENABLE_OFFSET, 32'h3C);
    apb(1'b1, ENABLE_OFFSET, 32'hC3);
    chk_reg(ENABLE_OFFSET, 32'h3C);
    init_rq <= 1'b0; init_ak <= 1'b0;
    chk_reg(ENABLE_OFFSET, 32'h3C);
  endtask
  task automatic t_events;
    apb(1'b1, ENABLE_OFFSET, 32'h03);
    pulse(3'h4);
    `CHK(wake_irq_o, 1'b0)
    pulse(3'h2);
    `CHK(error_irq_o, 1'b1)
    pulse(3'h1);
    `CHK(rx_irq_o, 1'b1)
    chk_reg(FLAG_OFFSET, 32'h83);
    apb(1'b1, ENABLE_OFFSET, 32'h80);
    w3;
    `CHK({wake_irq_o, error_irq_o, rx_irq_o, irq_o}, 4'h9)
    apb(1'b1, FLAG_OFFSET, 32'hC3);
    w3;
    `CHK(irq_o, 1'b0)
  endtask
  task automatic t_tx;
    apb(1'b1, ENABLE_OFFSET, 32'h44);
    txc <= 9'd100;
    w3;
    chk_reg(FLAG_OFFSET, 32'h04);
    txc <= 9'h100;
    w3;
    chk_reg(FLAG_OFFSET, 32'h7C);
    `CHK(error_irq_o, 1'b1)
    txc <= 9'd32;
    w3;
    chk_reg(FLAG_OFFSET, 32'h7C);
    apb(1'b1, FLAG_OFFSET, 32'h40);
    w3;
    chk_reg(FLAG_OFFSET, 32'h40);
    apb(1'b1, FLAG_OFFSET, 32'h40);
    w3;
    chk_reg(FLAG_OFFSET, 32'h0);
  endtask
  task automatic t_rx;
    apb(1'b1, ENABLE_OFFSET, 32'h60);
    rxc <= 9'd100;
    w3;
    chk_reg(FLAG_OFFSET, 32'h10);
    rxc <= 9'd200;
    w3;
    chk_reg(FLAG_OFFSET, 32'h60);
    apb(1'b1, FLAG_OFFSET, 32'h40);
    txc <= 9'h100;
    w3;
    chk_reg(FLAG_OFFSET, 32'h7C);
    apb(1'b1, ENABLE_OFFSET, 32'h4C);
    apb(1'b1, FLAG_OFFSET, 32'h40);
    rxc <= 9'd0;
    txc <= 9'd100;
    w3;
    chk_reg(FLAG_OFFSET, 32'h44);
    `CHK(seen !== 8'h00, 1'b1)
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; ev = 3'h0; rxc = 9'h0; txc = 9'h0;
    init_rq = 1'b0; init_ak = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_init;
    t_events;
    t_tx;
    t_rx;
    end_of_test;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test;
  end
endmodule
